/* File: rtl/ubfm_pkg.sv */
package ubfm_pkg;
   // Register byte offsets.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQST  = 8'h08;
   localparam logic [7:0] ADDR_IRQMSK = 8'h0C;
   localparam logic [7:0] ADDR_CMD    = 8'h10;
   // Control register fields.
   localparam int CTRL_HOST   = 0;
   localparam int CTRL_OUTDIR = 1;
   localparam int CTRL_CTRLEP = 2;
   localparam int CTRL_FREEZE = 3;
   localparam int CTRL_SOF    = 4;
   localparam int CTRL_PING   = 5;
   localparam int CTRL_STALL  = 6;
   localparam int CTRL_NBLO   = 8;
   // Status fields.
   localparam int ST_SENT   = 0;
   localparam int ST_HOFF   = 1;
   localparam int ST_ERR    = 2;
   localparam int ST_DIR    = 17;
   localparam int ST_ACC    = 16;
   localparam int ST_CURLO  = 14;
   localparam int ST_BUSYLO = 12;
   // Interrupt bits.
   localparam int IRQ_SENT  = 0;
   localparam int IRQ_BUSY  = 1;
   localparam int IRQ_W     = 2;
   // Command bits (write one).
   localparam int CMD_SENTC = 0;
   localparam int CMD_HOFFC = 1;
   localparam int CMD_ERRC  = 2;
   // Reset value and bank count limit.
   localparam logic [31:0] CTRL_RST = 32'h0000_0218;
   localparam logic [1:0]  BANKS_MAX = 2'h3;
   // Busy-count settle delay after a handoff clear, in cycles.
   localparam logic [1:0]  BUSY_DLY = 2'h2;
   typedef struct packed {
      logic       setupSeen;
      logic       nextIn;
      logic       pktDone;
      logic       bankFilled;
      logic       error;
   } ubfm_link_t;
   typedef enum logic [1:0] {
      UBFM_IDLE = 2'b00,
      UBFM_WAIT = 2'b01,
      UBFM_SEND = 2'b11
   } ubfm_state_t;
endpackage : ubfm_pkg

/* File: rtl/ubfm_bank_mgr.sv */
// Functional notes
// [R01] Software configures and unfreezes the pipe before any OUT transfer happens.
// [R02] When the current OUT bank frees, set sent flag and handoff bit together.
// [R03] Pipe interrupt rises when sent flag is set and its enable is one.
// [R04] Writing sent-clear clears only the sent flag, banks untouched.
// [R05] Clearing handoff releases the bank, advances bank, reloads flags from next bank.
// [R06] Software clears the sent flag before clearing the handoff bit.
// [R07] Host OUT pipe: access allowed while the current bank is not full.
// [R08] Suspend request with a bank ready is overridden and the bank is sent.
// [R09] High-speed host handles PING itself; a ping enable tunes it.
// [R10] After SETUP, direction flag clears for following OUT, sets for following IN.
// [R11] Device: access allowed on IN when bank not full, OUT when not empty.
// [R12] Access allowed stays clear on stall request, error, or any other case.
// [R13] Software should not rely on access allowed for control endpoints.
// [R14] Current bank index in bits 15:14; values 0..2, 3 reserved.
// [R15] Current bank may change one cycle after access allowed changes; here the bank index and access allowed are registered on the same edge.
// [R16] Busy count in 13:12; IN endpoint interrupt when all banks free.
// [R17] OUT endpoint busy count tracks host fills; interrupt when all busy.
// [R18] Busy count updates two or three cycles after a handoff clear.
// [R19] Current bank pointer wraps from last configured bank back to zero.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ubfm_bank_mgr (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic               clkEn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   // USB link side
   input  wire ubfm_pkg::ubfm_link_t linkIn,
   output logic                    bankReady,
   output logic                    pingActive,
   output logic                    sofRun,
   // Interrupt
   output logic                    irq
);
   logic [31:0] ctrl_ff;
   logic [1:0]  curBank_ff;
   logic [2:0]  full_ff;
   logic        sent_ff, hoff_ff, err_ff, dir_ff;
   logic [1:0]  busy_ff;
   logic [1:0]  dly_ff;
   logic        acc_ff;
   localparam int IRQ_W_L = ubfm_pkg::IRQ_W;
   logic [IRQ_W_L-1:0] irqSt_ff, irqMsk_ff;
   ubfm_pkg::ubfm_state_t state_ff;

   logic wrEn, rdEn, cmdWr, sentClr, hoffClr, errClr, host, outDir, frozen, stall, ctrlEp;
   logic [1:0] nBanks, lastBank, nxtBank, fullCnt;
   logic curFull, sentEv, busyEv, nxt_acc;
   logic relEv, sentSet, nxtFull;

   assign wrEn    = psel & penable & pwrite & clkEn;
   assign rdEn    = psel & ~pwrite;
   assign pready  = 1'b1;
   assign cmdWr   = wrEn && paddr == ubfm_pkg::ADDR_CMD;
   assign sentClr = cmdWr & pwdata[ubfm_pkg::CMD_SENTC];
   assign hoffClr = cmdWr & pwdata[ubfm_pkg::CMD_HOFFC];
   assign errClr  = cmdWr & pwdata[ubfm_pkg::CMD_ERRC];
   assign host    = ctrl_ff[ubfm_pkg::CTRL_HOST];
   assign outDir  = ctrl_ff[ubfm_pkg::CTRL_OUTDIR];
   assign frozen  = ctrl_ff[ubfm_pkg::CTRL_FREEZE];
   assign stall   = ctrl_ff[ubfm_pkg::CTRL_STALL];
   assign ctrlEp  = ctrl_ff[ubfm_pkg::CTRL_CTRLEP];
   assign nBanks  = (ctrl_ff[ubfm_pkg::CTRL_NBLO +: 2] == 2'h0) ? 2'h1 :
                    (ctrl_ff[ubfm_pkg::CTRL_NBLO +: 2] > ubfm_pkg::BANKS_MAX) ? ubfm_pkg::BANKS_MAX :
                    ctrl_ff[ubfm_pkg::CTRL_NBLO +: 2];
   assign lastBank = nBanks - 2'h1;
   assign nxtBank  = (curBank_ff >= lastBank) ? 2'h0 : curBank_ff + 2'h1; // [R19]
   assign curFull  = full_ff[curBank_ff];
   assign fullCnt  = 2'(full_ff[0]) + 2'(full_ff[1]) + 2'(full_ff[2]);

   // Register write side.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff   <= ubfm_pkg::CTRL_RST;
         irqMsk_ff <= '0;
      end else if (wrEn) begin
         if (paddr == ubfm_pkg::ADDR_CTRL) begin
            ctrl_ff <= pwdata;
         end
         if (paddr == ubfm_pkg::ADDR_IRQMSK) begin
            irqMsk_ff <= pwdata[IRQ_W_L-1:0];
         end
      end
   end

   // Link event stream: host pipes and device IN banks drain, a peer fills device OUT banks.
   // The pipe is idle while frozen, so nothing moves before software unfreezes it.
   logic drainEv, fillEv, oldest;
   logic [1:0] txBank_ff;
   assign drainEv = linkIn.pktDone & (host | ~outDir) & ~frozen & (state_ff == ubfm_pkg::UBFM_SEND); // [R01]
   assign fillEv  = linkIn.bankFilled & ~host & outDir & ~frozen & ~full_ff[txBank_ff];
   assign oldest  = 1'b0;

   // Releasing a host pipe from freeze hands its free current bank to software.
   assign relEv   = wrEn & (paddr == ubfm_pkg::ADDR_CTRL) & frozen & ~pwdata[ubfm_pkg::CTRL_FREEZE] &
                    pwdata[ubfm_pkg::CTRL_HOST] & hoff_ff & ~curFull; // [R02]
   // With one bank the next bank is the one just handed off, so its new state is used.
   assign nxtFull = (nxtBank == curBank_ff) ? (host | ~outDir) : full_ff[nxtBank];

   // Bank occupancy, current bank pointer and handoff bit.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         full_ff    <= 3'h0;
         curBank_ff <= 2'h0;
         txBank_ff  <= 2'h0;
         hoff_ff    <= 1'b1;
         sent_ff    <= 1'b0;
      end else if (clkEn) begin
         // Release and advance on handoff clear; flags reload from the next bank.
         if (hoffClr && hoff_ff) begin // [R05]
            curBank_ff <= nxtBank; // [R19]
            hoff_ff    <= nxtFull != (host | ~outDir); // [R05]
            sent_ff    <= host & ~nxtFull; // [R05]
         end else if (sentEv) begin
            hoff_ff <= 1'b1; // [R02]
            sent_ff <= 1'b1; // [R02]
         end else if (sentClr) begin
            sent_ff <= 1'b0; // [R04]
         end
         for (int i = 0; i < 3; i++) begin
            if (hoffClr && hoff_ff && curBank_ff == 2'(i)) begin
               full_ff[i] <= host | ~outDir;
            end else if ((drainEv | fillEv) && txBank_ff == 2'(i)) begin
               full_ff[i] <= fillEv;
            end
         end
         if (drainEv | fillEv) begin
            txBank_ff <= (txBank_ff >= lastBank) ? 2'h0 : txBank_ff + 2'h1;
         end
      end
   end
   // A sent event fires when the bank under software frees while it was waiting for it.
   assign sentEv  = (host & drainEv & (txBank_ff == curBank_ff) & ~hoff_ff) | relEv; // [R02]
   assign sentSet = sentEv | (hoffClr & hoff_ff & host & ~nxtFull); // [R05]

   // Transmit sequencer: suspend is overridden while a bank waits to go out.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ubfm_pkg::UBFM_IDLE;
      end else if (clkEn) begin
         unique case (state_ff)
            ubfm_pkg::UBFM_IDLE: if (|full_ff && (host | ~outDir) && !frozen) state_ff <= ubfm_pkg::UBFM_WAIT;
            ubfm_pkg::UBFM_WAIT: state_ff <= ubfm_pkg::UBFM_SEND;
            ubfm_pkg::UBFM_SEND: if (drainEv && fullCnt == 2'h1) state_ff <= ubfm_pkg::UBFM_IDLE;
         endcase
      end
   end
   assign bankReady  = state_ff == ubfm_pkg::UBFM_SEND;
   assign sofRun     = ctrl_ff[ubfm_pkg::CTRL_SOF] | (host & |full_ff); // [R08]
   assign pingActive = host & ctrl_ff[ubfm_pkg::CTRL_PING] & bankReady; // [R09]

   // Control direction and error flag.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_ff <= 1'b0;
         err_ff <= 1'b0;
      end else if (clkEn) begin
         if (linkIn.setupSeen && ctrlEp && !host) begin
            dir_ff <= linkIn.nextIn; // [R10]
         end
         if (linkIn.error) begin
            err_ff <= 1'b1;
         end else if (errClr) begin
            err_ff <= 1'b0;
         end
      end
   end

   // Access-allowed flag; it and the bank index are registered on the same edge, both one cycle behind the bank pointer.
   always_comb begin
      nxt_acc = 1'b0; // [R12]
      if (stall || err_ff) begin
         nxt_acc = 1'b0; // [R12]
      end else if (host || !outDir) begin
         nxt_acc = ~curFull; // [R07] [R11]
      end else begin
         nxt_acc = curFull; // [R11]
      end
   end
   logic [1:0] curBankRep_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_ff        <= 1'b0;
         curBankRep_ff <= 2'h0;
      end else if (clkEn) begin
         acc_ff        <= nxt_acc;
         curBankRep_ff <= ctrlEp ? 2'h0 : curBank_ff; // [R14] [R15]
      end
   end

   // Busy count refreshes a fixed delay after a handoff clear so the next address settles.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_ff <= 2'h0;
         dly_ff  <= 2'h0;
      end else if (clkEn) begin
         if (hoffClr && hoff_ff) begin
            dly_ff <= ubfm_pkg::BUSY_DLY; // [R18]
         end else if (dly_ff != 2'h0) begin
            dly_ff <= dly_ff - 2'h1;
         end
         if (dly_ff == 2'h1 || (dly_ff == 2'h0 && !(hoffClr && hoff_ff))) begin
            busy_ff <= fullCnt; // [R16] [R17]
         end
      end
   end
   assign busyEv = (!outDir && busy_ff == 2'h0) || (outDir && busy_ff == nBanks); // [R16] [R17]

   // Sticky interrupt status, set beats clear.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqSt_ff <= '0;
      end else if (clkEn) begin
         if (wrEn && paddr == ubfm_pkg::ADDR_IRQST) begin
            irqSt_ff <= irqSt_ff & ~pwdata[IRQ_W_L-1:0];
         end
         if (sentSet) irqSt_ff[ubfm_pkg::IRQ_SENT] <= 1'b1; // [R03]
         if (busyEv && !host) irqSt_ff[ubfm_pkg::IRQ_BUSY] <= 1'b1;
      end
   end
   assign irq = |(irqSt_ff & irqMsk_ff); // [R03] [R16]

   // Read side.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clkEn && rdEn && !penable) begin
         pslverr <= 1'b0;
         unique case (paddr)
            ubfm_pkg::ADDR_CTRL:   prdata <= ctrl_ff;
            ubfm_pkg::ADDR_STATUS: prdata <= {14'h0000, dir_ff, acc_ff, curBankRep_ff, busy_ff,
                                              9'h000, err_ff, hoff_ff, sent_ff};
            ubfm_pkg::ADDR_IRQST:  prdata <= {30'h0000_0000, irqSt_ff};
            ubfm_pkg::ADDR_IRQMSK: prdata <= {30'h0000_0000, irqMsk_ff};
            default: begin
               prdata  <= 32'h0000_0000;
               pslverr <= paddr != ubfm_pkg::ADDR_CMD;
            end
         endcase
      end
   end

   a_sent_irq: assert property (@(posedge clk) disable iff (!arst_n) // [R03]
      clkEn && sentSet |=> irqSt_ff[ubfm_pkg::IRQ_SENT]) else $error("sent flag did not raise status");
   a_sent_pair: assert property (@(posedge clk) disable iff (!arst_n) // [R02]
      $rose(sent_ff) |-> hoff_ff) else $error("sent flag without handoff bit");
   a_acc_stall: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
      $past(stall) && $past(clkEn) |-> !acc_ff) else $error("access allowed under stall");
   a_bank_range: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
      curBankRep_ff != 2'h3) else $error("reserved bank index");
   a_sent_clear: assert property (@(posedge clk) disable iff (!arst_n) // [R04]
      clkEn && sentClr && !sentEv && !hoffClr && !(drainEv | fillEv) |=> !sent_ff && $stable(full_ff))
      else $error("sent clear bad");
   a_busy_delay: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
      clkEn && hoffClr && hoff_ff |=> dly_ff == ubfm_pkg::BUSY_DLY) else $error("busy delay not started");
   a_dir_setup: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
      clkEn && linkIn.setupSeen && ctrlEp && !host |=> dir_ff == $past(linkIn.nextIn)) else $error("direction wrong");
   a_bank_wrap: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
      curBank_ff <= ubfm_pkg::BANKS_MAX - 2'h1) else $error("bank pointer out of range");

   a_irq_mask: assert property (@(posedge clk) disable iff (!arst_n) // [R03]
      irqSt_ff[ubfm_pkg::IRQ_SENT] && irqMsk_ff[ubfm_pkg::IRQ_SENT] |-> irq) else $error("masked irq missing");

   a_sent_set: assert property (@(posedge clk) disable iff (!arst_n) // [R02]
      clkEn && sentEv && !(hoffClr && hoff_ff) |=> sent_ff && hoff_ff) else $error("sent event lost");

   a_hoff_adv: assert property (@(posedge clk) disable iff (!arst_n) // [R05]
      clkEn && hoffClr && hoff_ff |=> curBank_ff == $past(nxtBank)) else $error("bank did not advance");

   a_hoff_full: assert property (@(posedge clk) disable iff (!arst_n) // [R05]
      clkEn && hoffClr && hoff_ff |=> full_ff[$past(curBank_ff)] == $past(host | ~outDir))
      else $error("handed bank state wrong");

   a_frozen_idle: assert property (@(posedge clk) disable iff (!arst_n) // [R01]
      clkEn && frozen && state_ff == ubfm_pkg::UBFM_IDLE |=> state_ff == ubfm_pkg::UBFM_IDLE)
      else $error("frozen pipe started");

   a_acc_host: assert property (@(posedge clk) disable iff (!arst_n) // [R07]
      clkEn && !stall && !err_ff && host |=> acc_ff == !$past(curFull)) else $error("host access flag wrong");

   a_acc_devout: assert property (@(posedge clk) disable iff (!arst_n) // [R11]
      clkEn && !stall && !err_ff && !host && outDir |=> acc_ff == $past(curFull))
      else $error("device OUT access flag wrong");

   a_acc_err: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
      clkEn && err_ff |=> !acc_ff) else $error("access allowed under error");

   a_sof_force: assert property (@(posedge clk) disable iff (!arst_n) // [R08]
      host && |full_ff |-> sofRun) else $error("suspend not overridden");

   a_ping_host: assert property (@(posedge clk) disable iff (!arst_n) // [R09]
      pingActive |-> host && bankReady) else $error("ping outside host send");

   a_bank_lag: assert property (@(posedge clk) disable iff (!arst_n) // [R15]
      clkEn && !ctrlEp |=> curBankRep_ff == $past(curBank_ff)) else $error("bank index lag wrong");

   a_bank_ctrl: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
      clkEn && ctrlEp |=> curBankRep_ff == 2'h0) else $error("control endpoint bank index");

   a_busy_irq: assert property (@(posedge clk) disable iff (!arst_n) // [R16]
      clkEn && busyEv && !host |=> irqSt_ff[ubfm_pkg::IRQ_BUSY]) else $error("busy status not set");

   a_busy_hold: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
      dly_ff == 2'h2 |=> $stable(busy_ff)) else $error("busy count moved early");

   a_busy_load: assert property (@(posedge clk) disable iff (!arst_n) // [R18]
      clkEn && dly_ff == 2'h1 |=> busy_ff == $past(fullCnt)) else $error("busy count not loaded");

   a_state_legal: assert property (@(posedge clk) disable iff (!arst_n) // [R05]
      state_ff inside {ubfm_pkg::UBFM_IDLE, ubfm_pkg::UBFM_WAIT, ubfm_pkg::UBFM_SEND})
      else $error("illegal sequencer state");

   a_dir_hold: assert property (@(posedge clk) disable iff (!arst_n) // [R10]
      clkEn && !(linkIn.setupSeen && ctrlEp && !host) |=> $stable(dir_ff)) else $error("direction moved");

   a_err_set: assert property (@(posedge clk) disable iff (!arst_n) // [R12]
      clkEn && linkIn.error |=> err_ff) else $error("error flag not set");

   a_next_range: assert property (@(posedge clk) disable iff (!arst_n) // [R19]
      nxtBank < nBanks) else $error("next bank beyond configured banks");

   a_fill_busy: assert property (@(posedge clk) disable iff (!arst_n) // [R17]
      clkEn && fillEv && !(hoffClr && hoff_ff && curBank_ff == txBank_ff) |=> full_ff[$past(txBank_ff)])
      else $error("filled bank not busy");

   a_drain_free: assert property (@(posedge clk) disable iff (!arst_n) // [R05]
      clkEn && drainEv && !(hoffClr && hoff_ff && curBank_ff == txBank_ff) |=> !full_ff[$past(txBank_ff)])
      else $error("sent bank not freed");

endmodule : ubfm_bank_mgr
`default_nettype wire

/* File: dv/ubfm_usb_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ubfm_usb_peer (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   // Bench requests
   input  wire ubfm_pkg::ubfm_link_t evt,
   input  wire logic [7:0]           dly,
   // Link side
   input  wire logic                 bankReady,
   output var ubfm_pkg::ubfm_link_t  linkIn
);
   logic [7:0] cnt_ff;
   logic       done_ff;
   // One completion per stretch of bankReady high; a large delay is how the far end stalls the pipe.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff  <= 8'h00;
         done_ff <= 1'b0;
      end else begin
         done_ff <= bankReady && (cnt_ff == dly - 8'h01);
         cnt_ff  <= !bankReady ? 8'h00 : ((cnt_ff == dly) ? cnt_ff : cnt_ff + 8'h01);
      end
   end
   always_comb begin
      linkIn         = evt;
      linkIn.pktDone = evt.pktDone | done_ff;
   end
endmodule : ubfm_usb_peer
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                 clk, arst_n, clkEn, psel, penable, pwrite;
   logic                 pready, pslverr, bankReady, pingActive, sofRun, irq;
   logic [7:0]           paddr, dly;
   logic [31:0]          pwdata, prdata, seed;
   logic [32:0]          qe[$], qm[$];
   ubfm_pkg::ubfm_link_t linkIn, evt;
   int                   errors, n_checks;
   ubfm_bank_mgr u_dut (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .linkIn(linkIn), .bankReady(bankReady), .pingActive(pingActive),
      .sofRun(sofRun), .irq(irq));
   ubfm_usb_peer u_peer (.clk(clk), .arst_n(arst_n), .evt(evt), .dly(dly), .bankReady(bankReady),
      .linkIn(linkIn));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic timeout();
      errors++;
      report_and_stop();
   endtask : timeout
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic rst();
      arst_n <= 1'b0;
      idle(12);
      arst_n <= 1'b1;
      @(posedge clk);
   endtask : rst
   // The request is held until pready is seen high, released right after that edge, then one idle edge follows.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (n > 50) timeout();
      end while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      qm.push_back(m);
      qe.push_back(e & m);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd
   task automatic pulse(input logic [4:0] v);
      evt <= ubfm_pkg::ubfm_link_t'(v);
      @(posedge clk);
      evt <= 5'h00;
      idle(4);
   endtask : pulse
   task automatic wait_ready(input logic lvl);
      int n;
      n = 0;
      while (bankReady !== lvl) begin
         @(posedge clk);
         n++;
         if (n > 200) timeout();
      end
   endtask : wait_ready
   // Read results are judged against the oldest note at the edge that completes the read.
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite && qe.size() > 0) begin
         chk({pslverr, prdata} & qm[0], qe[0]);
         void'(qe.pop_front());
         void'(qm.pop_front());
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {clkEn, arst_n, evt, dly, errors, n_checks} = '0;
      clkEn = 1'b1;
      seed = 32'hE0C1_16CB;
      rst();
      rd(ubfm_pkg::ADDR_CTRL, {1'b0, ubfm_pkg::CTRL_RST}, 33'h0_FFFF_FFFF);
      rd(8'hFC, 33'h1_0000_0000, 33'h1_0000_0000);
      clkEn <= 1'b0;
      wr(ubfm_pkg::ADDR_CTRL, 32'h0000_0000);
      clkEn <= 1'b1;
      rd(ubfm_pkg::ADDR_CTRL, {1'b0, ubfm_pkg::CTRL_RST}, 33'h0_FFFF_FFFF);
      repeat (4) begin
         seed = xs(seed);
         wr(ubfm_pkg::ADDR_IRQMSK, seed);
         rd(ubfm_pkg::ADDR_IRQMSK, {1'b0, seed}, 33'h3);
      end
      $display("test registers done");
      wr(ubfm_pkg::ADDR_CTRL, 32'h0000_0202);
      rd(ubfm_pkg::ADDR_STATUS, 33'h0, 33'h1_3000);
      pulse(5'b00010);
      rd(ubfm_pkg::ADDR_STATUS, 33'h1_1000, 33'h1_3000);
      wr(ubfm_pkg::ADDR_CTRL, 32'h0000_0242);
      rd(ubfm_pkg::ADDR_STATUS, 33'h0, 33'h1_0000);
      wr(ubfm_pkg::ADDR_CTRL, 32'h0000_0202);
      wr(ubfm_pkg::ADDR_IRQMSK, 32'h0000_0002);
      wr(ubfm_pkg::ADDR_IRQST, 32'h0000_0003);
      pulse(5'b00010);
      rd(ubfm_pkg::ADDR_STATUS, 33'h2000, 33'h3000);
      rd(ubfm_pkg::ADDR_IRQST, 33'h2, 33'h2);
      chk({32'h0, irq}, 33'h1);
      wr(ubfm_pkg::ADDR_CMD, 32'h0000_0002);
      idle(3);
      rd(ubfm_pkg::ADDR_STATUS, 33'h1000, 33'h3000);
      wr(ubfm_pkg::ADDR_CTRL, 32'h0000_0206);
      for (int i = 1; i >= 0; i--) begin
         pulse({1'b1, i[0], 3'b000});
         rd(ubfm_pkg::ADDR_STATUS, {15'h0, i[0], 17'h0}, 33'h2_0000);
      end
      $display("test device done");
      rst();
      wr(ubfm_pkg::ADDR_IRQMSK, 32'h0000_0001);
      wr(ubfm_pkg::ADDR_CTRL, 32'h0000_0213);
      idle(4);
      rd(ubfm_pkg::ADDR_STATUS, 33'h1_0003, 33'h1_0003);
      chk({32'h0, irq}, 33'h1);
      wr(ubfm_pkg::ADDR_IRQST, 32'h0000_0001);
      chk({32'h0, irq}, 33'h0);
      wr(ubfm_pkg::ADDR_CMD, 32'h0000_0001);
      rd(ubfm_pkg::ADDR_STATUS, 33'h2, 33'h3);
      dly <= 8'd20;
      for (int k = 1; k <= 2; k++) begin
         wr(ubfm_pkg::ADDR_CMD, 32'h0000_0001);
         wr(ubfm_pkg::ADDR_CMD, 32'h0000_0002);
         wait_ready(1'b1);
         if (k == 1) begin
            wr(ubfm_pkg::ADDR_CTRL, 32'h0000_0223);
            @(negedge clk);
            chk({32'h0, sofRun}, 33'h1);
            chk({32'h0, pingActive}, 33'h1);
         end
         wait_ready(1'b0);
         idle(4);
         rd(ubfm_pkg::ADDR_STATUS, {18'h0, k[0], 14'h3}, 33'hC003);
      end
      rd(ubfm_pkg::ADDR_IRQST, 33'h1, 33'h1);
      $display("test host done");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
